/* File: twm_pkg.sv */
// Summary of operation
// - Step-done flag sets after each bus step except STOP
// - Status code posted after every completed step
// - Writing one clears flag; bus waits otherwise
// - After START, send address-plus-read or address-plus-write, sample acknowledge
// - After repeated START, read or write address
// - Arbitration loss posts code, releases bus
// - Lost, begin set: START once bus free
// - Read address acknowledged: post code, receive byte
// - Acknowledge enable latched at clear picks ACK
// - Read address refused: post code, await choice
// - End request sends STOP, then self-clears
// - Begin and end together: STOP then START
// - Byte received with ACK: post code, hold
// - Byte received with NACK: post code, await choice
// - Write address acknowledged posts its own code
// - Data byte acknowledged posts its own code
`default_nettype none
package twm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BIT_RATE_HZ = 100_000;
  localparam int QUARTER_CYC = CLK_HZ / (4 * BIT_RATE_HZ);

  localparam logic [7:0] LINK_CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATE_CODE_OFS = 8'h04;
  localparam logic [7:0] BYTE_SHIFT_OFS = 8'h08;

  localparam int CTL_FLAG_BIT = 7;
  localparam int CTL_ACK_BIT = 6;
  localparam int CTL_BEGIN_BIT = 5;
  localparam int CTL_END_BIT = 4;
  localparam int CTL_EN_BIT = 2;

  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RESTART = 8'h10;
  localparam logic [7:0] CODE_TX_ADDR_ACK = 8'h18;
  localparam logic [7:0] CODE_TX_ADDR_NACK = 8'h20;
  localparam logic [7:0] CODE_TX_BYTE_ACK = 8'h28;
  localparam logic [7:0] CODE_TX_BYTE_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_RX_ADDR_ACK = 8'h40;
  localparam logic [7:0] CODE_RX_ADDR_NACK = 8'h48;
  localparam logic [7:0] CODE_RX_BYTE_ACK = 8'h50;
  localparam logic [7:0] CODE_RX_BYTE_NACK = 8'h58;
  localparam logic [7:0] CODE_NONE = 8'hf8;

  localparam logic [7:0] SHIFT_RST = 8'hff;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [4:0] {
    TWM_IDLE  = 5'b00001,
    TWM_START = 5'b00010,
    TWM_XFER  = 5'b00100,
    TWM_STOP  = 5'b01000,
    TWM_HOLD  = 5'b10000
  } twm_state_t;

  typedef struct packed {
    logic flag;
    logic ack_en;
    logic begin_c;
    logic end_c;
    logic en;
  } twm_ctrl_t;

  localparam twm_ctrl_t CTRL_RST = '{flag: 1'b0, ack_en: 1'b0, begin_c: 1'b0,
                                     end_c: 1'b0, en: 1'b0};

  typedef struct packed {
    logic scl;
    logic sda;
  } twm_line_t;
endpackage : twm_pkg
`default_nettype wire

/* File: twm_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module twm_sync #(
  parameter int W = 2
) (
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [W-1:0] async_in, // Lines from pins
  output logic [W-1:0] sync_out // Lines in mclk domain
);
  initial begin
    if (W < 1) $error("twm_sync: W must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic hold_q;
      // Idle bus lines float high, so reset to one
      always_ff @(posedge mclk) begin
        if (srst) begin
          meta_q <= 1'b1;
          hold_q <= 1'b1;
        end else begin
          meta_q <= async_in[i];
          hold_q <= meta_q;
        end
      end
      assign sync_out[i] = hold_q;
    end
  endgenerate
endmodule : twm_sync
`default_nettype wire

/* File: twm_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module twm_tick #(
  parameter int DIV = 250
) (
  input wire logic mclk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic run, // Count while high, restart when low
  output logic tick // One-cycle quarter-bit enable
);
  initial begin
    if (DIV < 2) $error("twm_tick: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] TOP = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (srst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q == TOP) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = run && (cnt_q == TOP);
endmodule : twm_tick
`default_nettype wire

/* File: twm_top.sv */
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module twm_top (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic scl_i, // Clock line level
  output logic scl_o, // Clock line drive value
  output logic scl_oe_n, // Clock line pulled low when zero
  input wire logic sda_i, // Data line level
  output logic sda_o, // Data line drive value
  output logic sda_oe_n // Data line pulled low when zero
);
  import twm_pkg::*;

  twm_state_t state_q;
  twm_ctrl_t ctrl_q;
  twm_line_t line_s;
  twm_line_t line_p;
  logic [1:0] line_v;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] code_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic own_q;
  logic busy_q;
  logic addr_q;
  logic rx_q;
  logic ackq_q;
  logic ack_in_q;
  logic scl_low_q;
  logic sda_low_q;
  logic set_flag_q;
  logic clr_end_q;
  logic qtick;
  logic run;
  logic setup;
  logic wr_go;
  logic hit;
  logic wr_ctrl;
  logic clr_go;
  logic start_seen;
  logic stop_seen;
  logic [7:0] ctrl_rd;

  twm_sync #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({scl_i, sda_i}),
    .sync_out(line_v)
  );
  assign line_s = line_v;

  assign run = (state_q == TWM_START) || (state_q == TWM_XFER) || (state_q == TWM_STOP);

  twm_tick #(
    .DIV(QUARTER_CYC)
  ) u_tick (
    .mclk(mclk),
    .srst(srst),
    .run(run),
    .tick(qtick)
  );

  // Open-drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~scl_low_q;
  assign sda_oe_n = ~sda_low_q;

  // Bus-free tracking from conditions seen on the synchronised lines
  always_ff @(posedge mclk) begin
    if (srst) begin
      line_p <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      line_p <= line_s;
    end
  end
  assign start_seen = line_p.scl && line_s.scl && line_p.sda && !line_s.sda;
  assign stop_seen = line_p.scl && line_s.scl && !line_p.sda && line_s.sda;

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else if (stop_seen) begin
      busy_q <= 1'b0;
    end else if (start_seen) begin
      busy_q <= 1'b1;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign hit = (paddr == LINK_CONTROL_OFS) || (paddr == STATE_CODE_OFS) ||
               (paddr == BYTE_SHIFT_OFS);
  assign wr_go = psel && penable && pready && pwrite && hit;
  assign wr_ctrl = wr_go && (paddr == LINK_CONTROL_OFS);
  // Only a write carrying the flag bit while waiting clears the flag and starts the next step
  assign clr_go = wr_ctrl && pwdata[CTL_FLAG_BIT] && ctrl_q.flag &&
                  (state_q == TWM_HOLD);

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[CTL_FLAG_BIT] = ctrl_q.flag;
    ctrl_rd[CTL_ACK_BIT] = ctrl_q.ack_en;
    ctrl_rd[CTL_BEGIN_BIT] = ctrl_q.begin_c;
    ctrl_rd[CTL_END_BIT] = ctrl_q.end_c;
    ctrl_rd[CTL_EN_BIT] = ctrl_q.en;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit;
      unique case (paddr)
        LINK_CONTROL_OFS: prdata_q <= {24'h000000, ctrl_rd};
        STATE_CODE_OFS: prdata_q <= {24'h000000, code_q};
        BYTE_SHIFT_OFS: prdata_q <= {24'h000000, shift_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Control bits; a hardware set of the flag wins over a clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.ack_en <= pwdata[CTL_ACK_BIT];
        ctrl_q.begin_c <= pwdata[CTL_BEGIN_BIT];
        ctrl_q.end_c <= pwdata[CTL_END_BIT];
        ctrl_q.en <= pwdata[CTL_EN_BIT];
      end else if (clr_end_q) begin
        ctrl_q.end_c <= 1'b0;
      end
      if (set_flag_q) begin
        ctrl_q.flag <= 1'b1;
      end else if (clr_go) begin
        ctrl_q.flag <= 1'b0;
      end
    end
  end

  // Bus engine; each bit spans five quarter ticks, as the clock-release phase waits one extra tick
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= TWM_IDLE;
      phase_q <= 2'd0;
      bit_q <= 4'h0;
      shift_q <= SHIFT_RST;
      code_q <= CODE_NONE;
      own_q <= 1'b0;
      addr_q <= 1'b0;
      rx_q <= 1'b0;
      ackq_q <= 1'b0;
      ack_in_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      set_flag_q <= 1'b0;
      clr_end_q <= 1'b0;
    end else begin
      set_flag_q <= 1'b0;
      clr_end_q <= 1'b0;
      // Loading only while the engine is parked avoids corrupting a byte in flight
      if (wr_go && (paddr == BYTE_SHIFT_OFS) &&
          ((state_q == TWM_HOLD) || (state_q == TWM_IDLE))) begin
        shift_q <= pwdata[7:0];
      end
      if (!ctrl_q.en) begin
        state_q <= TWM_IDLE;
        phase_q <= 2'd0;
        own_q <= 1'b0;
        scl_low_q <= 1'b0;
        sda_low_q <= 1'b0;
        code_q <= CODE_NONE;
      end else begin
        unique case (state_q)
          TWM_IDLE: begin
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            // Also covers the retry after a lost arbitration
            if (ctrl_q.begin_c && !busy_q) begin
              state_q <= TWM_START;
              phase_q <= 2'd0;
            end
          end
          TWM_HOLD: begin
            scl_low_q <= own_q;
            if (clr_go) begin
              phase_q <= 2'd0;
              bit_q <= 4'h0;
              ackq_q <= pwdata[CTL_ACK_BIT];
              if (pwdata[CTL_END_BIT] && own_q) begin
                state_q <= TWM_STOP;
              end else if (pwdata[CTL_BEGIN_BIT]) begin
                // Not owning the bus: wait in idle for it to go free
                state_q <= own_q ? TWM_START : TWM_IDLE;
              end else if (!own_q) begin
                state_q <= TWM_IDLE;
              end else begin
                state_q <= TWM_XFER;
                addr_q <= (code_q == CODE_START) || (code_q == CODE_RESTART);
                rx_q <= (code_q == CODE_RX_ADDR_ACK) ||
                        (code_q == CODE_RX_BYTE_ACK);
              end
            end
          end
          TWM_START: begin
            if (qtick) begin
              unique case (phase_q)
                2'd0: begin
                  sda_low_q <= 1'b0;
                  phase_q <= 2'd1;
                end
                2'd1: begin
                  scl_low_q <= 1'b0;
                  if (line_s.scl) begin
                    phase_q <= 2'd2;
                  end
                end
                2'd2: begin
                  sda_low_q <= 1'b1;
                  phase_q <= 2'd3;
                end
                2'd3: begin
                  scl_low_q <= 1'b1;
                  own_q <= 1'b1;
                  code_q <= own_q ? CODE_RESTART : CODE_START;
                  set_flag_q <= 1'b1;
                  state_q <= TWM_HOLD;
                end
              endcase
            end
          end
          TWM_XFER: begin
            if (qtick) begin
              unique case (phase_q)
                2'd0: begin
                  if (bit_q == LAST_BIT) begin
                    sda_low_q <= rx_q && ackq_q;
                  end else begin
                    sda_low_q <= !rx_q && !shift_q[7];
                  end
                  phase_q <= 2'd1;
                end
                2'd1: begin
                  scl_low_q <= 1'b0;
                  if (line_s.scl) begin
                    phase_q <= 2'd2;
                  end
                end
                2'd2: begin
                  phase_q <= 2'd3;
                  // Released line read low while we own it means another master
                  if (!sda_low_q && !line_s.sda &&
                      ((!rx_q && (bit_q != LAST_BIT)) ||
                       (rx_q && (bit_q == LAST_BIT)))) begin
                    state_q <= TWM_HOLD;
                    own_q <= 1'b0;
                    scl_low_q <= 1'b0;
                    sda_low_q <= 1'b0;
                    code_q <= CODE_ARB_LOST;
                    set_flag_q <= 1'b1;
                  end else if (bit_q == LAST_BIT) begin
                    ack_in_q <= !line_s.sda;
                  end else begin
                    shift_q <= {shift_q[6:0], line_s.sda};
                  end
                end
                2'd3: begin
                  scl_low_q <= 1'b1;
                  phase_q <= 2'd0;
                  if (bit_q == LAST_BIT) begin
                    sda_low_q <= 1'b0;
                    set_flag_q <= 1'b1;
                    state_q <= TWM_HOLD;
                    if (rx_q) begin
                      code_q <= ackq_q ? CODE_RX_BYTE_ACK : CODE_RX_BYTE_NACK;
                    end else if (addr_q && shift_q[0]) begin
                      code_q <= ack_in_q ? CODE_RX_ADDR_ACK : CODE_RX_ADDR_NACK;
                    end else if (addr_q) begin
                      code_q <= ack_in_q ? CODE_TX_ADDR_ACK : CODE_TX_ADDR_NACK;
                    end else begin
                      code_q <= ack_in_q ? CODE_TX_BYTE_ACK : CODE_TX_BYTE_NACK;
                    end
                  end else begin
                    bit_q <= bit_q + 4'h1;
                  end
                end
              endcase
            end
          end
          TWM_STOP: begin
            if (qtick) begin
              unique case (phase_q)
                2'd0: begin
                  sda_low_q <= 1'b1;
                  phase_q <= 2'd1;
                end
                2'd1: begin
                  scl_low_q <= 1'b0;
                  if (line_s.scl) begin
                    phase_q <= 2'd2;
                  end
                end
                2'd2: begin
                  sda_low_q <= 1'b0;
                  phase_q <= 2'd3;
                end
                2'd3: begin
                  // A STOP raises no flag; a pending begin restarts from idle
                  own_q <= 1'b0;
                  clr_end_q <= 1'b1;
                  code_q <= CODE_NONE;
                  state_q <= TWM_IDLE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule : twm_top
`default_nettype wire

/* File: twm_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module twm_monitor (
  input wire logic mclk, // Clock
  input wire logic srst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic scl_i, // Clk line
  input wire logic scl_o, // Clk drive
  input wire logic scl_oe_n, // Clk pull
  input wire logic sda_i, // Data line
  input wire logic sda_o, // Data drive
  input wire logic sda_oe_n // Data pull
);
  import twm_pkg::*;
  logic hold_q;
  logic hold_d;
  logic acc;
  logic ctl;
  logic mapped;
  assign acc = psel && penable && pready;
  assign ctl = acc && paddr == LINK_CONTROL_OFS;
  assign mapped = paddr inside {LINK_CONTROL_OFS, STATE_CODE_OFS, BYTE_SHIFT_OFS};
  // Flag seen set while the clock line is ours; only a clearing or disabling write ends it
  always_comb begin
    hold_d = hold_q;
    if (ctl && !pwrite && prdata[CTL_FLAG_BIT] && !scl_oe_n) hold_d = 1'b1;
    if (ctl && pwrite && (pwdata[CTL_FLAG_BIT] || !pwdata[CTL_EN_BIT])) hold_d = 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (srst) hold_q <= 1'b0;
    else hold_q <= hold_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  chk_scl_held: assert property (hold_q |-> !scl_oe_n)
    else $error("clock line let go while waiting");
  chk_lines_frozen: assert property (hold_q && $past(hold_q) |-> $stable(sda_oe_n))
    else $error("data line moved while waiting");
  chk_stop_release: assert property ($rose(sda_oe_n) && scl_oe_n && scl_i
    |=> (scl_oe_n && sda_oe_n) [*8]) else $error("bus not left free after stop");
  chk_start_shape: assert property ($fell(sda_oe_n) && scl_oe_n
    |-> scl_oe_n [*8] ##[1:400] !scl_oe_n) else $error("bad start shape");
  chk_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  chk_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("error on mapped address");
  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("access not ready");
  chk_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Open-drain lines may only ever be pulled low, never driven high
  chk_open_drain: assert property (!scl_o && !sda_o)
    else $error("line drive value not low");
endmodule : twm_monitor
bind twm_top twm_monitor mon_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n));
`default_nettype wire

/* File: twm_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h64
) (
  input wire logic scl, // Clock line
  input wire logic sda, // Data line
  input wire logic [7:0] tx_byte, // Byte sent on reads
  output logic sda_n // Zero pulls data low
);
  logic act = 0, adr = 0, hit = 0, rd = 0, mnack = 0;
  logic [3:0] cnt = 0;
  logic [7:0] sh = 0;
  initial sda_n = 1'b1;
  always @(negedge sda) if (scl) begin
    act = 1;
    adr = 1;
    hit = 0;
    mnack = 0;
    cnt = 4'h0;
    sda_n = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    act = 0;
    sda_n = 1'b1;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda};
    else if (rd && !adr) mnack = sda;
    cnt = cnt + 4'h1;
  end
  // Changes only while the clock is low, so no false start or stop is made
  always @(negedge scl) if (act) begin
    if (cnt == 4'h8) begin
      if (adr) begin
        hit = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      sda_n = !(hit && (adr || !rd));
    end else begin
      if (cnt == 4'h9) begin
        cnt = 4'h0;
        adr = 0;
      end
      sda_n = !(hit && rd && !adr && !mnack) || tx_byte[3'd7 - cnt[2:0]];
    end
  end
endmodule : twm_slave_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import twm_pkg::*;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0, sdat = 8'ha5;
  logic [31:0] pwdata = 0, prdata, rv;
  logic pready, pslverr, scl_oe_n, sda_oe_n, slv_n, scl_w, sda_w;
  int n_fail = 0, checked = 0;
  // Both lines have pull-ups: released means high
  assign scl_w = scl_oe_n;
  assign sda_w = sda_oe_n & slv_n;
  twm_top dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(),
    .sda_oe_n(sda_oe_n));
  twm_slave_model slv_u (.scl(scl_w), .sda(sda_w), .tx_byte(sdat), .sda_n(slv_n));
  initial forever #5 mclk = ~mclk;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task automatic code(input logic [7:0] c);
    int i;
    for (i = 0; i < 5000; i++) begin
      xfer(0, LINK_CONTROL_OFS, 0);
      if (rv[CTL_FLAG_BIT] === 1'b1) break;
    end
    xfer(0, STATE_CODE_OFS, 0);
    `CHK("code", c, rv[7:0])
  endtask : code
  task automatic wait_end();
    int i;
    for (i = 0; i < 2000; i++) begin
      xfer(0, LINK_CONTROL_OFS, 0);
      if (rv[CTL_END_BIT] === 1'b0) break;
    end
    `CHK("end", 1'b0, rv[CTL_END_BIT])
  endtask : wait_end
  task automatic go(input logic [7:0] sh, input logic [7:0] c);
    xfer(1, BYTE_SHIFT_OFS, {24'h0, sh});
    xfer(1, LINK_CONTROL_OFS, {24'h0, c});
  endtask : go
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    // About 87k cycles of bus traffic expected; stop at 95k
    #950_000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 0;
    xfer(0, 8'h0c, 0);
    `CHK("unmapped", 1'b1, err)
    xfer(1, STATE_CODE_OFS, 0);
    xfer(0, STATE_CODE_OFS, 0);
    `CHK("idle", {24'h0, CODE_NONE}, rv)
    `CHK("ok", 1'b0, err)
    xfer(0, BYTE_SHIFT_OFS, 0);
    `CHK("shift", {24'h0, SHIFT_RST}, rv)
    xfer(1, LINK_CONTROL_OFS, 32'h24);
    code(CODE_START);
    xfer(1, LINK_CONTROL_OFS, 32'h24);
    code(CODE_START);
    go(8'hc9, 8'h84);
    code(CODE_RX_ADDR_ACK);
    xfer(1, LINK_CONTROL_OFS, 32'hc4);
    code(CODE_RX_BYTE_ACK);
    `CHK("ack", 1'b0, slv_u.mnack)
    xfer(0, BYTE_SHIFT_OFS, 0);
    `CHK("rx0", 32'ha5, rv)
    sdat <= 8'hbc;
    xfer(1, LINK_CONTROL_OFS, 32'h84);
    code(CODE_RX_BYTE_NACK);
    `CHK("nack", 1'b1, slv_u.mnack)
    xfer(0, BYTE_SHIFT_OFS, 0);
    `CHK("rx1", 32'hbc, rv)
    xfer(1, LINK_CONTROL_OFS, 32'h94);
    wait_end();
    xfer(0, STATE_CODE_OFS, 0);
    `CHK("stop", {24'h0, CODE_NONE}, rv)
    xfer(1, LINK_CONTROL_OFS, 32'h24);
    code(CODE_START);
    go(8'h45, 8'h84);
    code(CODE_RX_ADDR_NACK);
    xfer(1, LINK_CONTROL_OFS, 32'hb4);
    code(CODE_START);
    xfer(0, LINK_CONTROL_OFS, 0);
    `CHK("end2", 1'b0, rv[CTL_END_BIT])
    go(8'hc8, 8'h84);
    code(CODE_TX_ADDR_ACK);
    go(8'h33, 8'h84);
    code(CODE_TX_BYTE_ACK);
    `CHK("wr", 8'h33, slv_u.sh)
    xfer(1, LINK_CONTROL_OFS, 32'ha4);
    code(CODE_RESTART);
    go(8'hc9, 8'h84);
    code(CODE_RX_ADDR_ACK);
    xfer(1, LINK_CONTROL_OFS, 32'h94);
    wait_end();
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
